// ### hdl/watchdog_mode_control.sv
// watchdog timer with mode selection, sleep handling and register slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
module watchdog_mode_control (
    input  wire logic                       REF_CLK,
    input  wire logic                       RST_N,
    input  wire logic                       LOW_FREQ_INTERNAL_OSC,
    input  wire logic [1:0]                 WATCHDOG_MODE_SELECT,
    input  wire logic                       SLEEP,
    input  wire logic                       CLEAR_WATCHDOG_INSTRUCTION,
    input  wire logic                       OSC_FAIL,
    input  wire logic [wdt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [31:0]                S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    output logic [1:0]                      S_AXI_BRESP,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    input  wire logic [wdt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    output logic [31:0]                     S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    output logic                            DEVICE_RESET,
    output logic                            WAKE
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0]        load_cnt;
        logic              cfg_loaded;
        logic [1:0]        mode;
        ctrl_t             ctrl;
        flags_t            flags;
        logic              sleep;
        logic [CNT_W-1:0]  cnt;
        logic              dev_rst;
        logic              wake;
        logic              awready;
        logic              wready;
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0]        wdata;
        logic              wstrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } top_state_t;

    localparam ctrl_t      CTRL_RESET  = '{ps: PS_RESET, swen: SWEN_RESET};
    localparam top_state_t STATE_RESET = '{ctrl: CTRL_RESET, default: '0};

    top_state_t       s_q;
    top_state_t       s_d;
    logic             rst_sync_n;
    logic             tick;
    logic             osc_fail_s;
    logic [1:0]       mode_pins_s;
    logic             run;
    logic             clr_any;
    logic             terminal;
    logic             to_awake;
    logic             to_sleep;
    logic [CNT_W-1:0] mask;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
        if (addr == CTRL_ADDR) begin
            reg_sel = SEL_CTRL;
        end else if (addr == STAT_ADDR) begin
            reg_sel = SEL_STAT;
        end else begin
            reg_sel = SEL_NONE;
        end
    endfunction

    // reserved prescale codes above the top behave as the longest timeout
    function automatic logic [CNT_W-1:0] term_mask(input logic [PS_W-1:0] ps);
        logic [PS_W-1:0] eff;
        eff       = (ps > PS_MAX) ? PS_MAX : ps;
        term_mask = CNT_W'((19'h0_0001 << eff) - 19'h0_0001);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release, pin synchronisers, base tick

    wdt_sync #(.W(1)) u_rst_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .d     (1'b1),
        .q     (rst_sync_n)
    );

    wdt_sync #(.W(3)) u_pin_sync (
        .clk   (REF_CLK),
        .rst_n (rst_sync_n),
        .d     ({OSC_FAIL, WATCHDOG_MODE_SELECT}),
        .q     ({osc_fail_s, mode_pins_s})
    );

    wdt_tick_gen u_tick (
        .clk                   (REF_CLK),
        .rst_n                 (rst_sync_n),
        .low_freq_internal_osc (LOW_FREQ_INTERNAL_OSC),
        .clr                   (clr_any),
        .tick                  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // run decision and counter clear

    always_comb begin
        case (s_q.mode)
            MODE_ALWAYS: run = 1'b1;
            MODE_AWAKE:  run = ~SLEEP;
            MODE_SW:     run = s_q.ctrl.swen;
            default:     run = 1'b0;
        endcase
        if (!s_q.cfg_loaded) begin
            run = 1'b0;
        end
    end

    // a clear in the terminal cycle wins, so no timeout fires then
    assign clr_any  = CLEAR_WATCHDOG_INSTRUCTION | (SLEEP != s_q.sleep) | osc_fail_s
                    | ~run;
    assign mask     = term_mask(s_q.ctrl.ps);
    assign terminal = tick & (s_q.cnt == mask);
    assign to_awake = ~clr_any & terminal & ~SLEEP;
    assign to_sleep = ~clr_any & terminal & SLEEP;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d         = s_q;
        s_d.sleep   = SLEEP;
        s_d.dev_rst = 1'b0;
        s_d.wake    = 1'b0;

        // mode straps are caught once, after the synchroniser has settled
        if (!s_q.cfg_loaded) begin
            s_d.load_cnt = s_q.load_cnt + 1'b1;
            if (s_q.load_cnt == CFG_LOAD_CYCLE) begin
                s_d.cfg_loaded = 1'b1;
                s_d.mode       = mode_pins_s;
            end
        end

        // counter
        if (clr_any) begin
            s_d.cnt = '0;
        end else if (tick) begin
            s_d.cnt = terminal ? '0 : s_q.cnt + 1'b1;
        end

        // write channel
        if (S_AXI_AWVALID && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s_q.wready) begin
            s_d.w_got  = 1'b1;
            s_d.wdata  = S_AXI_WDATA[7:0];
            s_d.wstrb0 = S_AXI_WSTRB[0];
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            if (reg_sel(s_q.awaddr) == SEL_CTRL) begin
                if (s_q.wstrb0) begin
                    s_d.ctrl.ps   = s_q.wdata[CTRL_PS_LSB +: PS_W];
                    s_d.ctrl.swen = s_q.wdata[CTRL_EN_BIT];
                end
            end else if (reg_sel(s_q.awaddr) == SEL_STAT) begin
                if (s_q.wstrb0) begin
                    s_d.flags.wdt_rst = s_q.flags.wdt_rst & ~s_q.wdata[STAT_WRST_BIT];
                    s_d.flags.to      = s_q.flags.to & ~s_q.wdata[STAT_TO_BIT];
                    s_d.flags.pd      = s_q.flags.pd & ~s_q.wdata[STAT_PD_BIT];
                end
            end else begin
                s_d.bresp = RESP_DECERR;
            end
        end else if (s_q.bvalid && S_AXI_BREADY) begin
            s_d.bvalid = 1'b0;
        end
        s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

        // read channel
        if (S_AXI_ARVALID && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = '0;
            s_d.rresp  = RESP_OKAY;
            if (reg_sel(S_AXI_ARADDR) == SEL_CTRL) begin
                s_d.rdata[CTRL_PS_LSB +: PS_W] = s_q.ctrl.ps;
                s_d.rdata[CTRL_EN_BIT]         = s_q.ctrl.swen;
            end else if (reg_sel(S_AXI_ARADDR) == SEL_STAT) begin
                s_d.rdata[STAT_WRST_BIT]      = s_q.flags.wdt_rst;
                s_d.rdata[STAT_TO_BIT]        = s_q.flags.to;
                s_d.rdata[STAT_PD_BIT]        = s_q.flags.pd;
                s_d.rdata[STAT_MODE_LSB +: 2] = s_q.mode;
                s_d.rdata[STAT_RUN_BIT]       = run;
            end else begin
                s_d.rresp = RESP_DECERR;
            end
        end else if (s_q.rvalid && S_AXI_RREADY) begin
            s_d.rvalid = 1'b0;
        end
        s_d.arready = ~s_d.rvalid;

        // timeout events; hardware sets win over a same-cycle clear
        if (to_awake) begin
            s_d.dev_rst       = 1'b1;
            s_d.flags.wdt_rst = 1'b1;
            s_d.flags.to      = 1'b1;
            s_d.ctrl          = CTRL_RESET;
        end
        if (to_sleep) begin
            s_d.wake     = 1'b1;
            s_d.flags.to = 1'b1;
            s_d.flags.pd = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign S_AXI_AWREADY = s_q.awready;
    assign S_AXI_WREADY  = s_q.wready;
    assign S_AXI_BVALID  = s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_ARREADY = s_q.arready;
    assign S_AXI_RVALID  = s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;
    assign DEVICE_RESET  = s_q.dev_rst;
    assign WAKE          = s_q.wake;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!rst_sync_n);

    sequence seq_terminal_awake;
        terminal && !clr_any && !SLEEP;
    endsequence

    sequence seq_terminal_asleep;
        terminal && !clr_any && SLEEP;
    endsequence

    AST_AWAKE_TIMEOUT_RESETS: assert property (
        seq_terminal_awake |=> (DEVICE_RESET && !WAKE && s_q.flags.wdt_rst && s_q.cnt == '0))
        else $error("awake timeout did not reset the device");

    AST_SLEEP_TIMEOUT_WAKES: assert property (
        seq_terminal_asleep |=> (WAKE && !DEVICE_RESET && s_q.flags.to && s_q.flags.pd))
        else $error("sleep timeout did not wake the device");

    AST_RESET_RESTORES_PRESCALE: assert property (
        DEVICE_RESET |-> (s_q.ctrl.ps == PS_RESET && !s_q.ctrl.swen))
        else $error("prescale not back at default after watchdog reset");

    AST_OFF_MODE_STILL: assert property (
        (s_q.mode == MODE_OFF) |=> (s_q.cnt == '0 && !DEVICE_RESET && !WAKE))
        else $error("counter moved with watchdog off");

    AST_ALWAYS_COUNTS_IN_SLEEP: assert property (
        (s_q.cfg_loaded && s_q.mode == MODE_ALWAYS && SLEEP && $past(SLEEP) && tick
         && !CLEAR_WATCHDOG_INSTRUCTION && !osc_fail_s && !terminal)
        |=> (s_q.cnt == $past(s_q.cnt) + 1'b1))
        else $error("always-on watchdog not counting in sleep");

    AST_AWAKE_MODE_STOPS_IN_SLEEP: assert property (
        (s_q.mode == MODE_AWAKE && SLEEP) |=> (s_q.cnt == '0 && !WAKE))
        else $error("awake-only watchdog ran in sleep");

    AST_SW_MODE_FOLLOWS_ENABLE: assert property (
        (s_q.cfg_loaded && s_q.mode == MODE_SW && !s_q.ctrl.swen)
        |=> (s_q.cnt == '0 && !DEVICE_RESET && !WAKE))
        else $error("software mode ran with enable clear");

    AST_CLEAR_INSTRUCTION: assert property (
        CLEAR_WATCHDOG_INSTRUCTION |=> (s_q.cnt == '0 && !DEVICE_RESET && !WAKE))
        else $error("clear instruction did not clear the counter");

    AST_SLEEP_EDGE_CLEARS: assert property (
        (SLEEP != s_q.sleep) |=> (s_q.cnt == '0)[*2])
        else $error("sleep entry or exit did not clear the counter");

    AST_TIMEOUT_ONLY_AT_MASK: assert property (
        $rose(DEVICE_RESET) |-> ($past(tick) && $past(s_q.cnt) == $past(mask)))
        else $error("watchdog reset away from a terminal tick");
endmodule

// ### hdl/wdt_pkg.sv
// shared constants and carriers for the watchdog mode controller
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam int              ADDR_W     = 12;
    localparam logic [11:0]     CTRL_INDEX = 12'h097;
    localparam logic [11:0]     STAT_INDEX = 12'h098;
    localparam logic [11:0]     CTRL_ADDR  = 12'(CTRL_INDEX * 4);
    localparam logic [11:0]     STAT_ADDR  = 12'(STAT_INDEX * 4);

    // control register fields
    localparam int              CTRL_EN_BIT = 0;
    localparam int              CTRL_PS_LSB = 1;
    localparam int              PS_W        = 5;
    localparam logic [4:0]      PS_RESET    = 5'h0B;
    localparam logic [4:0]      PS_MAX      = 5'h12;
    localparam logic            SWEN_RESET  = 1'b0;

    // status register fields
    localparam int              STAT_WRST_BIT = 0;
    localparam int              STAT_TO_BIT   = 1;
    localparam int              STAT_PD_BIT   = 2;
    localparam int              STAT_MODE_LSB = 3;
    localparam int              STAT_RUN_BIT  = 5;

    // mode field encodings
    localparam logic [1:0]      MODE_OFF    = 2'h0;
    localparam logic [1:0]      MODE_SW     = 2'h1;
    localparam logic [1:0]      MODE_AWAKE  = 2'h2;
    localparam logic [1:0]      MODE_ALWAYS = 2'h3;

    // bus answers
    localparam logic [1:0]      RESP_OKAY   = 2'h0;
    localparam logic [1:0]      RESP_DECERR = 2'h3;
    localparam logic [1:0]      SEL_NONE    = 2'h0;
    localparam logic [1:0]      SEL_CTRL    = 2'h1;
    localparam logic [1:0]      SEL_STAT    = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int              LF_OSC_HZ          = 31_000;
    localparam int              TICK_PERIOD_US     = 1_000;
    localparam int              LF_CYCLES_PER_TICK = LF_OSC_HZ * TICK_PERIOD_US / 1_000_000;
    localparam int              DIV_W              = 5;
    localparam int              CNT_W              = 18;
    localparam logic [1:0]      CFG_LOAD_CYCLE     = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [PS_W-1:0] ps;
        logic            swen;
    } ctrl_t;

    typedef struct packed {
        logic wdt_rst;
        logic to;
        logic pd;
    } flags_t;

endpackage

// ### hdl/wdt_sync.sv
// two-flop synchroniser, also used to release the reset
`timescale 1ns/100ps
module wdt_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule

// ### hdl/wdt_tick_gen.sv
// 1 ms base tick from the low-frequency oscillator pin
`timescale 1ns/100ps
module wdt_tick_gen (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic low_freq_internal_osc,
    input  wire logic clr,
    output logic      tick
);
    import wdt_pkg::*;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LF_CYCLES_PER_TICK - 1);

    typedef struct packed {
        logic             lf_prev;
        logic [DIV_W-1:0] div;
        logic             tick;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;
    logic        lf_s;
    logic        lf_rise;

    // oscillator is asynchronous to the core clock
    wdt_sync #(.W(1)) u_lf_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (low_freq_internal_osc),
        .q     (lf_s)
    );

    assign lf_rise = lf_s & ~s_q.lf_prev;

    always_comb begin
        s_d         = s_q;
        s_d.lf_prev = lf_s;
        s_d.tick    = 1'b0;
        if (clr) begin
            s_d.div = '0;
        end else if (lf_rise) begin
            if (s_q.div == DIV_LAST) begin
                s_d.div  = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.div = s_q.div + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    AST_TICK_AFTER_FULL_DIVIDE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!clr && lf_rise && s_q.div == DIV_LAST) |=> (tick && s_q.div == '0))
        else $error("base tick missing after full divide");

    AST_TICK_ONLY_FROM_OSC: assert property (
        @(posedge clk) disable iff (!rst_n)
        tick |-> ($past(lf_rise) && !$past(clr)))
        else $error("base tick without oscillator edge");
endmodule

// ### sim/testbench.sv
// register-level testbench for the watchdog mode controller
`timescale 1ns/100ps
module testbench;
    import wdt_pkg::*;
    logic              REF_CLK = 1'b0;
    logic              RST_N = 1'b0;
    logic              osc = 1'b0;
    logic              osc_on = 1'b0;
    logic [1:0]        mode = 2'h3;
    logic              sleep = 1'b0;
    logic              clr = 1'b0;
    logic              ofail = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0]       wdata = '0;
    logic [3:0]        wstrb = '0;
    logic              awvalid = 1'b0;
    logic              wvalid = 1'b0;
    logic              bready = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid, dev_rst, wake;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic [1:0]        rsp;
    logic [31:0]       dat;
    int                n_fail = 0;
    int                total_checks = 0;

    int                osc_div = 0;

    always #2 REF_CLK = ~REF_CLK;
    // slow clock, rising edge every 8 core cycles, parked low when off
    always @(posedge REF_CLK) begin
        osc_div <= (osc_div + 1) % 4;
        if (osc_div == 3) begin
            osc <= osc_on & ~osc;
        end
    end

    watchdog_mode_control i_dut (
        .REF_CLK                    (REF_CLK),
        .RST_N                      (RST_N),
        .LOW_FREQ_INTERNAL_OSC      (osc),
        .WATCHDOG_MODE_SELECT       (mode),
        .SLEEP                      (sleep),
        .CLEAR_WATCHDOG_INSTRUCTION (clr),
        .OSC_FAIL                   (ofail),
        .S_AXI_AWADDR               (awaddr),
        .S_AXI_AWVALID              (awvalid),
        .S_AXI_AWREADY              (awready),
        .S_AXI_WDATA                (wdata),
        .S_AXI_WSTRB                (wstrb),
        .S_AXI_WVALID               (wvalid),
        .S_AXI_WREADY               (wready),
        .S_AXI_BRESP                (bresp),
        .S_AXI_BVALID               (bvalid),
        .S_AXI_BREADY               (bready),
        .S_AXI_ARADDR               (araddr),
        .S_AXI_ARVALID              (arvalid),
        .S_AXI_ARREADY              (arready),
        .S_AXI_RDATA                (rdata),
        .S_AXI_RRESP                (rresp),
        .S_AXI_RVALID               (rvalid),
        .S_AXI_RREADY               (rready),
        .DEVICE_RESET               (dev_rst),
        .WAKE                       (wake)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // all tasks are entered and left just after a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge REF_CLK);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge REF_CLK); while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge REF_CLK); while (!arready);
        arvalid <= 1'b0;
        do @(posedge REF_CLK); while (!rvalid);
        rsp = rresp;
        dat = rdata;
        rready <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic do_reset(input logic [1:0] m);
        RST_N <= 1'b0;
        osc_on <= 1'b0;
        sleep <= 1'b0;
        mode <= m;
        repeat (6) @(posedge REF_CLK);
        RST_N <= 1'b1;
        repeat (8) @(posedge REF_CLK);
    endtask

    // program control, clear counter and divider, start the slow clock
    task automatic arm(input logic [4:0] ps, input logic en);
        wr(CTRL_ADDR, {26'h0, ps, en}, 4'hF);
        clr <= 1'b1;
        @(posedge REF_CLK);
        clr <= 1'b0;
        osc_on <= 1'b1;
    endtask

    task automatic expect_ev(input int lo, input int hi, input logic r, input logic w);
        int n;
        n = 0;
        while (n < hi && !(dev_rst || wake)) begin
            @(posedge REF_CLK);
            n++;
        end
        chk("timeout too early", 32'(n >= lo), 32'h1);
        chk("reset pulse", 32'(dev_rst), 32'(r));
        chk("wake pulse", 32'(wake), 32'(w));
        @(posedge REF_CLK);
        chk("pulse width", 32'(dev_rst | wake), 32'h0);
        osc_on <= 1'b0;
    endtask

    task automatic no_ev(input int cyc);
        int hits;
        hits = 0;
        repeat (cyc) begin
            @(posedge REF_CLK);
            hits += int'(dev_rst | wake);
        end
        chk("unexpected timeout", 32'(hits), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge REF_CLK);
        n_fail++;
        finish_test();
    end

    initial begin
        @(posedge REF_CLK);
        do_reset(MODE_ALWAYS);
        rd(CTRL_ADDR);
        chk("ctrl reset", dat, 32'h0000_0016);
        rd(12'h000);
        chk("unmapped rresp", 32'(rsp), 32'(RESP_DECERR));
        chk("unmapped rdata", dat, 32'h0000_0000);
        wr(12'h264, 32'h0000_00FF, 4'hF);
        chk("unmapped bresp", 32'(rsp), 32'(RESP_DECERR));
        wr(CTRL_ADDR, 32'hFFFF_FFFF, 4'hF);
        rd(CTRL_ADDR);
        chk("ctrl bits", dat, 32'h0000_003F);
        wr(CTRL_ADDR, 32'h0000_0000, 4'h0);
        rd(CTRL_ADDR);
        chk("ctrl strobe", dat, 32'h0000_003F);
        // timeout length doubles per prescale step, 248 core cycles per ms
        for (int p = 0; p < 3; p++) begin
            arm(5'(p), 1'b0);
            expect_ev((248 << p) - 12, (248 << p) + 24, 1'b1, 1'b0);
            rd(STAT_ADDR);
            chk("status awake", dat, 32'h0000_003B);
            rd(CTRL_ADDR);
            chk("ctrl after reset", dat, 32'h0000_0016);
            wr(STAT_ADDR, 32'h0000_0007, 4'hF);
            rd(STAT_ADDR);
            chk("status cleared", dat, 32'h0000_0038);
        end
        // sleep in always-on mode wakes instead of resetting; two ticks so it counts asleep
        sleep <= 1'b1;
        arm(5'h01, 1'b0);
        expect_ev(484, 520, 1'b0, 1'b1);
        rd(STAT_ADDR);
        chk("status sleep", dat, 32'h0000_003E);
        sleep <= 1'b0;
        // clear instruction keeps restarting the count
        arm(5'h01, 1'b0);
        repeat (4) begin
            no_ev(300);
            clr <= 1'b1;
            @(posedge REF_CLK);
            clr <= 1'b0;
        end
        expect_ev(480, 540, 1'b1, 1'b0);
        // oscillator failure holds the counter at zero
        arm(5'h00, 1'b0);
        ofail <= 1'b1;
        no_ev(700);
        ofail <= 1'b0;
        expect_ev(228, 290, 1'b1, 1'b0);
        // awake-only mode stops in sleep
        do_reset(MODE_AWAKE);
        rd(STAT_ADDR);
        chk("mode field", dat & 32'h0000_0018, 32'h0000_0010);
        sleep <= 1'b1;
        arm(5'h00, 1'b0);
        no_ev(700);
        sleep <= 1'b0;
        expect_ev(228, 290, 1'b1, 1'b0);
        // software mode follows the enable bit only
        do_reset(MODE_SW);
        arm(5'h00, 1'b0);
        no_ev(700);
        wr(CTRL_ADDR, 32'h0000_0001, 4'h1);
        expect_ev(200, 290, 1'b1, 1'b0);
        sleep <= 1'b1;
        arm(5'h00, 1'b1);
        expect_ev(236, 272, 1'b0, 1'b1);
        sleep <= 1'b0;
        // off mode ignores the enable bit
        do_reset(MODE_OFF);
        arm(5'h00, 1'b1);
        no_ev(900);
        // strap changes after capture are ignored
        do_reset(MODE_ALWAYS);
        mode <= MODE_OFF;
        arm(5'h00, 1'b0);
        expect_ev(236, 272, 1'b1, 1'b0);
        finish_test();
    end
endmodule
